// ===== verilog/irqsc_top.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module irqsc_top
   import irqsc_pkg::*;
#(
   parameter logic [31:0] EXT_MASK = 32'h6000_0001  // which sources come from pins
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [AW-1:0]     paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // interrupt inputs
   input  wire logic              fast_irq_pin,
   input  wire logic [31:0]       ext_irq_pins,
   input  wire logic [31:0]       periph_irq,
   input  wire logic [7:0]        system_source,
   // core side
   output irqsc_core_s            core
);
   // the controller has no gating input at all: it runs whenever pclk runs [R16]

   logic [31:0] raw_in;
   logic [31:0] ext_s1_r, ext_s2_r;
   logic [31:0] src_prev_r;
   logic [31:0] edge_r;
   logic [31:0] mask_r;
   logic [31:0] ffen_r;
   logic [31:0] smr_r [NSRC];
   logic [4:0]  cur_r;
   logic [PRI_W-1:0] cur_pri_r;
   logic        busy_r;
   logic        gmask_r;
   logic        nreq_n_r, freq_n_r;
   logic [31:0] cond, pend_raw, is_edge;
   logic [4:0]  win_src;
   logic [PRI_W-1:0] win_pri;
   logic        win_any;
   logic        rd, wr;

   function automatic logic [PRI_W-1:0] pri_of(input logic [31:0] m);
      pri_of = m[PRI_LSB +: PRI_W];
   endfunction : pri_of

   function automatic logic [1:0] type_of(input logic [31:0] m);
      type_of = m[TYPE_LSB +: TYPE_W];
   endfunction : type_of

   // map inputs onto source numbers = peripheral identifiers [R22]
   always_comb begin
      raw_in = periph_irq;                                 // [R21]
      raw_in[SRC_FAST] = fast_irq_pin;                     // [R19]
      raw_in[SRC_SYS] = |system_source;                    // [R20]
      raw_in = (raw_in & ~EXT_MASK) | (ext_irq_pins & EXT_MASK);
      if (EXT_MASK[SRC_FAST])
         raw_in[SRC_FAST] = fast_irq_pin;
   end

   // pin inputs are resynchronised before any detection [R25]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_r <= 32'h0000_0000;
         ext_s2_r <= 32'h0000_0000;
      end else begin
         ext_s1_r <= raw_in;
         ext_s2_r <= ext_s1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         src_prev_r <= 32'h0000_0000;
      else
         src_prev_r <= ext_s2_r;
   end

   assign rd = psel && penable && !pwrite;
   assign wr = psel && penable && pwrite;

   // per-source condition from the type field [R1]
   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         is_edge[i] = type_of(smr_r[i])[0];                // [R2]
         if (EXT_MASK[i]) begin
            unique case (irqsc_type_e'(type_of(smr_r[i])))  // [R3]
               ST_LVL_LOW:  cond[i] = !ext_s2_r[i];
               ST_LVL_HIGH: cond[i] = ext_s2_r[i];
               ST_EDGE_NEG: cond[i] = src_prev_r[i] && !ext_s2_r[i];
               ST_EDGE_POS: cond[i] = !src_prev_r[i] && ext_s2_r[i];
            endcase
         end else if (is_edge[i]) begin
            cond[i] = !src_prev_r[i] && ext_s2_r[i];       // [R2]
         end else begin
            cond[i] = ext_s2_r[i];
         end
         pend_raw[i] = is_edge[i] ? edge_r[i] : cond[i];   // [R13]
      end
   end

   // edge memory: set wins over all clears [R9]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_r <= 32'h0000_0000;
      end else begin
         logic [31:0] clr;
         logic [31:0] set;
         clr = 32'h0000_0000;
         set = cond & is_edge;
         if (wr && paddr == OFS_CLR)
            clr = pwdata & is_edge;                        // [R7] [R8]
         if (wr && paddr == OFS_SET)
            set = set | (pwdata & is_edge);                // [R7] [R8]
         if (rd && paddr == OFS_NVEC && win_any && !ffen_r[win_src])
            clr[win_src] = 1'b1;                           // [R10] [R11]
         if (rd && paddr == OFS_FVEC)
            clr[SRC_FAST] = 1'b1;                          // [R12]
         edge_r <= (edge_r & ~clr) | set;
      end
   end

   // enable mask and fast forcing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= 32'h0000_0000;
         ffen_r <= 32'h0000_0000;
         gmask_r <= 1'b0;
      end else if (wr) begin
         if (paddr == OFS_EN)
            mask_r <= mask_r | pwdata;                     // [R4]
         if (paddr == OFS_DIS)
            mask_r <= mask_r & ~pwdata;                    // [R4]
         if (paddr == OFS_FFEN)
            ffen_r <= ffen_r | (pwdata & 32'hFFFF_FFFE);
         if (paddr == OFS_FFDIS)
            ffen_r <= ffen_r & ~pwdata;
         if (paddr == OFS_GCTL)
            gmask_r <= pwdata[GCTL_GMSK];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NSRC; i++)
            smr_r[i] <= SMR_RST;
      end else if (wr && paddr[AW-1:7] == 5'h00) begin
         smr_r[paddr[6:2]] <= pwdata;                      // [R1]
      end
   end

   // resolver: only enabled, non-forced sources 1..31 compete [R6]
   always_comb begin
      logic [31:0] cand;
      cand = pend_raw & mask_r & ~ffen_r;
      cand[SRC_FAST] = 1'b0;
      win_any = 1'b0;
      win_src = 5'h00;
      win_pri = 3'h0;
      for (int i = NSRC - 1; i >= 1; i--) begin
         // >= while scanning down lets the lowest number win ties [R24]
         if (cand[i] && (!win_any || pri_of(smr_r[i]) >= win_pri)) begin
            win_any = 1'b1;
            win_src = 5'(i);
            win_pri = pri_of(smr_r[i]);                    // [R23]
         end
      end
   end

   // current source: latched at vector read, released by end-of-interrupt.
   // nesting is one deep here; deeper stacking is outside this stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_r <= 5'h00;
         cur_pri_r <= 3'h0;
         busy_r <= 1'b0;
      end else if (rd && paddr == OFS_NVEC && win_any) begin
         cur_r <= win_src;                                 // [R14]
         cur_pri_r <= win_pri;
         busy_r <= 1'b1;
      end else if (wr && paddr == OFS_EOI) begin
         busy_r <= 1'b0;
      end
   end

   // request outputs registered, active low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nreq_n_r <= 1'b1;
         freq_n_r <= 1'b1;
      end else begin
         nreq_n_r <= !(win_any && !gmask_r && !(rd && paddr == OFS_NVEC)
                     && (!busy_r || win_pri > cur_pri_r));      // [R6]
         freq_n_r <= !(!gmask_r && |(pend_raw & mask_r & (ffen_r | 32'h0000_0001)));
      end
   end

   always_comb begin
      core.core_normal_request_n = nreq_n_r;
      core.core_fast_request_n = freq_n_r;
      // wake on any asserted request, and on any pending enabled event while the general mask is on [R17] [R18]
      core.wake = !nreq_n_r || !freq_n_r || (gmask_r && |(pend_raw & mask_r));
   end

   // apb: zero wait, unmapped addresses read zero and flag an error
   assign pready = 1'b1;
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (psel && penable) begin
         // only 0x000-0x07C hold mode words; the gap up to the vector register is unmapped
         if (paddr[AW-1:7] == 5'h00) begin
            prdata = pwrite ? 32'h0000_0000 : smr_r[paddr[6:2]];
         end else begin
            unique case (paddr)
               OFS_NVEC:  prdata = win_any ? {27'h0, win_src} : VEC_SPURIOUS;
               OFS_FVEC:  prdata = VEC_SPURIOUS;
               OFS_CUR:   prdata = {27'h0, cur_r};         // [R14]
               OFS_PEND:  prdata = pend_raw;               // [R13]
               OFS_MASK:  prdata = mask_r;                 // [R5]
               OFS_CORE:  prdata = {30'h0, !freq_n_r, !nreq_n_r}; // [R15]
               OFS_FFSR:  prdata = ffen_r | 32'h0000_0001;
               OFS_GCTL:  prdata = {31'h0, gmask_r};
               OFS_EN, OFS_DIS, OFS_CLR, OFS_SET, OFS_EOI, OFS_FFEN, OFS_FFDIS:
                          prdata = 32'h0000_0000;
               default:   pslverr = 1'b1;
            endcase
         end
      end
   end
endmodule : irqsc_top

// ===== verilog/irqsc_pkg.sv
// Overview of operation
// R1 - each source holds its own mode register; the type field picks its trigger
// R2 - internal sources choose level or edge; their polarity is fixed
// R3 - external sources choose high level, low level, rising or falling edge
// R4 - one write enables or disables sources; ones act, zeros are ignored
// R5 - the enable state reads back as a mask word
// R6 - disabled sources never take part in or block servicing
// R7 - set and clear commands force or remove pending on edge sources
// R8 - set and clear do nothing to level-sensitive sources
// R9 - a detected edge stays latched until cleared
// R10 - normal vector read clears only the current source's latched edge
// R11 - fast-forced sources are never auto-cleared by the normal vector read
// R12 - fast vector read clears source 0's latched edge
// R13 - pending register shows raw activity, masked or not
// R14 - current source register returns the serviced source number
// R15 - core status register mirrors both request outputs
// R16 - runs from an ungated clock regardless of power settings
// R17 - any asserted request output signals wake-up to an idle core
// R18 - with general mask on, wake-up still occurs without a request line
// R19 - source 0 is the fast interrupt pin
// R20 - source 1 is the OR of system peripheral lines
// R21 - sources 2 to 31 take peripheral or external lines
// R22 - source number equals the peripheral identifier
// R23 - each source has a 3-bit priority, 7 most urgent
// R24 - equal top priority resolves to the lowest source number
// R25 - external inputs pass two flip-flops before detection
package irqsc_pkg;
   localparam int unsigned NSRC = 32;
   localparam int unsigned AW   = 12;
   // register byte offsets
   localparam logic [AW-1:0] OFS_SMR0  = 12'h000;  // 32 words of source mode
   localparam logic [AW-1:0] OFS_NVEC  = 12'h100;
   localparam logic [AW-1:0] OFS_FVEC  = 12'h104;
   localparam logic [AW-1:0] OFS_CUR   = 12'h108;
   localparam logic [AW-1:0] OFS_PEND  = 12'h10C;
   localparam logic [AW-1:0] OFS_MASK  = 12'h110;
   localparam logic [AW-1:0] OFS_CORE  = 12'h114;
   localparam logic [AW-1:0] OFS_EN    = 12'h120;
   localparam logic [AW-1:0] OFS_DIS   = 12'h124;
   localparam logic [AW-1:0] OFS_CLR   = 12'h128;
   localparam logic [AW-1:0] OFS_SET   = 12'h12C;
   localparam logic [AW-1:0] OFS_EOI   = 12'h130;
   localparam logic [AW-1:0] OFS_FFEN  = 12'h140;
   localparam logic [AW-1:0] OFS_FFDIS = 12'h144;
   localparam logic [AW-1:0] OFS_FFSR  = 12'h148;
   localparam logic [AW-1:0] OFS_GCTL  = 12'h138;
   // source mode field layout
   localparam int unsigned PRI_LSB  = 0;
   localparam int unsigned PRI_W    = 3;
   localparam int unsigned TYPE_LSB = 5;
   localparam int unsigned TYPE_W   = 2;
   localparam int unsigned GCTL_GMSK = 0;
   localparam logic [31:0] SMR_RST  = 32'h0000_0000;
   localparam logic [4:0]  SRC_FAST = 5'h00;
   localparam logic [4:0]  SRC_SYS  = 5'h01;
   localparam logic [31:0] VEC_SPURIOUS = 32'h0000_0000;

   // source_type_field codes; internal sources only look at bit 0
   typedef enum logic [1:0] {
      ST_LVL_LOW  = 2'h0,
      ST_EDGE_NEG = 2'h1,
      ST_LVL_HIGH = 2'h2,
      ST_EDGE_POS = 2'h3
   } irqsc_type_e;

   typedef struct packed {
      logic       core_normal_request_n;
      logic       core_fast_request_n;
      logic       wake;
   } irqsc_core_s;
endpackage : irqsc_pkg

// ===== sim/irqsc_checker.sv
`timescale 1ns/10ps
module irqsc_checker
   import irqsc_pkg::*;
(
   // clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // apb
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   // core side
   input wire irqsc_core_s   core
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   logic req;
   assign acc = psel && penable;
   assign req = !(core.core_normal_request_n && core.core_fast_request_n);
   sequence wr_at(logic [AW-1:0] a);
      acc && pwrite && paddr == a;
   endsequence
   sequence rd_at(logic [AW-1:0] a);
      acc && !pwrite && paddr == a;
   endsequence
   a_zero_wait: assert property (acc |-> pready)
      else $error("pready low in access");
   a_unmapped_refused: assert property (rd_at(12'h1F0) |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_ok: assert property (acc && paddr == OFS_MASK |-> !pslverr)
      else $error("error flag on mapped access");
   a_wake_req: assert property (req |-> core.wake)
      else $error("request without wake");
   a_core_image: assert property (rd_at(OFS_CORE) |->
      prdata[1:0] == ~{core.core_fast_request_n, core.core_normal_request_n})
      else $error("core status differs from outputs");
   a_mask_set: assert property (wr_at(OFS_EN) ##3 rd_at(OFS_MASK) |-> (prdata & $past(pwdata, 3)) == $past(pwdata, 3))
      else $error("enabled bits missing from mask");
   a_mask_clear: assert property (wr_at(OFS_DIS) ##3 rd_at(OFS_MASK) |-> (prdata & $past(pwdata, 3)) == 32'h0)
      else $error("disabled bits still in mask");
   a_cur_follows: assert property (rd_at(OFS_NVEC) ##3 rd_at(OFS_CUR) |-> prdata == $past(prdata, 3))
      else $error("current source differs from vector");
   c_vector: cover property (rd_at(OFS_NVEC));
   c_fast: cover property (rd_at(OFS_FVEC));
   c_wake: cover property (core.wake);
endmodule : irqsc_checker

bind irqsc_top irqsc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .core(core));

// ===== sim/irqsc_partner.sv
`timescale 1ns/10ps
module irqsc_partner (
   // line requests from the bench, changed just after a clock edge
   input  wire logic [31:0] act,
   // interrupt lines toward the block
   output logic             fast_irq_pin,
   output logic [31:0]      ext_irq_pins,
   output logic [31:0]      periph_irq,
   output logic [7:0]       system_source
);
   // pins idle high as if pulled up, so low-level pin sources stay quiet
   assign fast_irq_pin  = ~act[0];
   assign ext_irq_pins  = ~act;
   assign periph_irq    = act & 32'hFFFF_FFFC;
   assign system_source = act[1] ? 8'h10 : 8'h00;
endmodule : irqsc_partner

// ===== sim/irq_source_control_tb.sv
`timescale 1ns/10ps
module irq_source_control_tb
   import irqsc_pkg::*;
;
   typedef struct packed {logic w; logic c; logic [AW-1:0] a; logic [31:0] d;} irqsc_row_s;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, fast_irq_pin;
   logic [AW-1:0] paddr;
   logic [31:0]   pwdata, prdata, act, ext_irq_pins, periph_irq, q;
   logic [7:0]    system_source;
   irqsc_core_s   core;
   int            bad_count, tests_run;
   irqsc_row_s    rows [16];

   irqsc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fast_irq_pin(fast_irq_pin), .ext_irq_pins(ext_irq_pins),
      .periph_irq(periph_irq), .system_source(system_source), .core(core));
   irqsc_partner u_far (.act(act), .fast_irq_pin(fast_irq_pin),
      .ext_irq_pins(ext_irq_pins), .periph_irq(periph_irq), .system_source(system_source));

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
      if (n >= 50) summarize();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_req(input logic fast);
      int n;
      n = 0;
      while ((fast ? core.core_fast_request_n : core.core_normal_request_n) !== 1'b0
             && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) chk("request", 32'h0, 32'h1);
      if (n == 20) summarize();
   endtask : wait_req

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, act, presetn} = '0;
      rows = '{'{0, 1, OFS_MASK, 32'h0}, '{1, 0, OFS_EN, 32'h8000_0003},
               '{0, 1, OFS_MASK, 32'h8000_0003}, '{1, 0, OFS_DIS, 32'h2},
               '{0, 1, OFS_MASK, 32'h8000_0001}, '{0, 1, 12'h1F0, 32'h0},
               '{1, 0, 12'h008, 32'h25}, '{0, 1, 12'h008, 32'h25},
               '{1, 0, 12'h00C, 32'h20}, '{1, 0, OFS_SET, 32'h8},
               '{0, 1, OFS_PEND, 32'h8}, '{1, 0, OFS_CLR, 32'h8},
               '{0, 1, OFS_PEND, 32'h0}, '{1, 0, 12'h010, 32'h0},
               '{1, 0, OFS_SET, 32'h10}, '{0, 1, OFS_PEND, 32'h0}};
      repeat (20) @(posedge pclk);
      chk("core in reset", 32'h6, {29'h0, core});
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (rows[i].c) chk("row", rows[i].d, q);
      end
      // source 5 as rising edge, priority 7; a one-cycle pulse must stay latched
      apb(1'b1, 12'h014, 32'h27);
      apb(1'b1, OFS_EN, 32'h20);
      act[5] <= 1'b1;
      @(posedge pclk);
      act[5] <= 1'b0;
      wait_req(1'b0);
      chk("wake", 32'h1, {31'h0, core.wake});
      apb(1'b0, OFS_PEND, 32'h0);
      chk("latched", 32'h20, q);
      apb(1'b0, OFS_NVEC, 32'h0);
      chk("vector", 32'h5, q);
      apb(1'b0, OFS_CUR, 32'h0);
      chk("current", 32'h5, q);
      apb(1'b0, OFS_PEND, 32'h0);
      chk("auto clear", 32'h0, q);
      apb(1'b1, OFS_EOI, 32'h0);
      // source 0 on falling pin edge, cleared by the fast vector read
      apb(1'b1, OFS_SMR0, 32'h20);
      act[0] <= 1'b1;
      @(posedge pclk);
      act[0] <= 1'b0;
      wait_req(1'b1);
      apb(1'b0, OFS_CORE, 32'h0);
      chk("core image", 32'h2, q);
      apb(1'b0, OFS_FVEC, 32'h0);
      apb(1'b0, OFS_PEND, 32'h0);
      chk("fast clear", 32'h0, q);
      // masked system line still shows as pending
      act[1] <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b0, OFS_PEND, 32'h0);
      chk("raw pending", 32'h2, q);
      summarize();
   end
endmodule : irq_source_control_tb
